// file: verilog/ctad_datapath.sv
`timescale 1ns/10ps
// Notes on behaviour
// RULE_01 - Move byte/word/long: reg to reg, memory to reg, reg to memory, immediate to reg.
// RULE_02 - Both peripheral-synchronised byte moves are refused as illegal.
// RULE_03 - Pop is a move from stack pointer address, then post-increment.
// RULE_04 - Push pre-decrements the stack pointer, then writes the register there.
// RULE_05 - Multi-register restore pops two or more longwords from consecutive stack slots.
// RULE_06 - Multi-register save pushes two or more longwords with pre-decrement.
// RULE_07 - The stack pointer register may not appear in a multi-register list.
// RULE_08 - Add/subtract reg-reg or imm-reg, any size, result to destination.
// RULE_09 - Byte subtract of an immediate is refused.
// RULE_10 - Byte-only add/subtract including carry, reg or immediate source.
// RULE_11 - Increment/decrement a register by one or two, any size.
// RULE_12 - Byte increment/decrement allows only a step of one.
// RULE_13 - Longword pointer add/subtract of one, two or four, no flags.
// RULE_14 - Byte decimal adjust after add and subtract, using carry and half-carry.
// RULE_15 - Unsigned multiply 8x8 to 16 or 16x16 to 32 into destination.
// RULE_16 - Signed multiply with the same widths.
// RULE_17 - Unsigned divide 16/8 or 32/16, quotient low half, remainder high half.
// RULE_18 - Immediates and displacements may be 8, 16, 24 or 32 bits long.
// RULE_19 - Eight 32-bit registers, seen as 16-bit low/extended and 8-bit halves.
// RULE_20 - Carry flag set on add carry or subtract borrow, else cleared.
// RULE_21 - Overflow flag set on two's-complement overflow, else cleared.
// RULE_22 - Word/long accesses force address bit zero low, no error raised. Multi-register save/restore aligns only its first access.
// RULE_23 - Negative/zero follow each result; divide leaves flags unchanged.
// RULE_24 - Save runs high register to low, restore low to high.
module ctad_datapath
	import ctad_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        ce,
	input  wire logic        cmd_valid,
	input  ctad_cmd_s        cmd,
	output logic             cmd_ready,
	output logic             done,
	output logic             illegal,
	output ctad_flags_s      flags,
	output logic             mem_req,
	output logic             mem_we,
	output ctad_size_e       mem_size,
	output logic [31:0]      mem_addr,
	output logic [31:0]      mem_wdata,
	input  wire logic [31:0] mem_rdata,
	input  wire logic        mem_ack,
	input  wire logic [2:0]  peek_idx,
	output logic [31:0]      peek_data
);
	logic [31:0] gr [8];
	logic [31:0] next_gr [8];
	ctad_state_e st, next_st;
	ctad_cmd_s   cur, next_cur;
	logic [7:0]  left, next_left;
	ctad_flags_s next_fl;
	logic        next_rdy, next_done, next_ill, next_req, next_we;
	ctad_size_e  next_size;
	logic [31:0] next_addr, next_wdata, next_peek;
	logic [31:0] sp, opa, opb, val, ea;
	logic [2:0]  ri;
	logic        bad;
	ctad_alu_s   alu;

	// Halves: byte code bit3 picks low byte, word code bit3 picks extended half
	function automatic logic [31:0] rget(input logic [31:0] w, input logic [3:0] i, input ctad_size_e s);
		case (s)
			SZ_B:    rget = 32'(i[3] ? w[7:0] : w[15:8]); // [RULE_19]
			SZ_W:    rget = 32'(i[3] ? w[31:16] : w[15:0]);
			default: rget = w;
		endcase
	endfunction

	function automatic logic [31:0] wput(input logic [31:0] w, input logic [3:0] i, input ctad_size_e s,
		input logic [31:0] v);
		wput = w;
		case (s)
			SZ_B:    if (i[3]) wput[7:0] = v[7:0]; else wput[15:8] = v[7:0]; // [RULE_19]
			SZ_W:    if (i[3]) wput[31:16] = v[15:0]; else wput[15:0] = v[15:0];
			default: wput = v;
		endcase
	endfunction

	function automatic logic [31:0] fext(input logic [31:0] v, input ctad_len_e l, input logic sgn);
		case (l)
			LEN_8:   fext = {{24{sgn & v[7]}}, v[7:0]}; // [RULE_18]
			LEN_16:  fext = {{16{sgn & v[15]}}, v[15:0]};
			LEN_24:  fext = {{8{sgn & v[23]}}, v[23:0]};
			default: fext = v;
		endcase
	endfunction

	function automatic logic [31:0] align(input logic [31:0] a, input ctad_size_e s);
		align = (s == SZ_B) ? a : {a[31:1], 1'b0}; // [RULE_22]
	endfunction

	// Operands are moved to the top of the word so one adder serves all sizes
	function automatic ctad_alu_s addsub(input logic [31:0] a, input logic [31:0] b, input logic ci,
		input logic sb, input ctad_size_e s);
		logic [4:0]  sh;
		logic [31:0] at, bt;
		logic [32:0] t, hs;
		sh = (s == SZ_B) ? 5'd24 : (s == SZ_W) ? 5'd16 : 5'd0;
		at = a << sh;
		bt = (sb ? ~b : b) << sh;
		t = {1'b0, at} + {1'b0, bt} + ({32'h0000_0000, ci ^ sb} << sh);
		hs = {1'b0, at << 4} + {1'b0, bt << 4} + ({32'h0000_0000, ci ^ sb} << (sh + 5'd4));
		addsub.r = t[31:0] >> sh;
		addsub.c = t[32] ^ sb; // [RULE_20]
		addsub.v = (at[31] == bt[31]) && (t[31] != at[31]); // [RULE_21]
		addsub.h = hs[32] ^ sb;
	endfunction

	function automatic ctad_flags_s setnz(input ctad_flags_s f, input logic [31:0] r, input ctad_size_e s);
		setnz = f;
		setnz.n = (s == SZ_B) ? r[7] : (s == SZ_W) ? r[15] : r[31]; // [RULE_23]
		setnz.z = (r == REG_RST);
	endfunction

	function automatic logic [2:0] lowbit(input logic [7:0] l);
		lowbit = 3'h0;
		for (int k = 7; k >= 0; k--) if (l[k]) lowbit = 3'(k);
	endfunction

	function automatic logic [2:0] highbit(input logic [7:0] l);
		highbit = 3'h0;
		for (int k = 0; k < 8; k++) if (l[k]) highbit = 3'(k);
	endfunction

	function automatic logic [3:0] lcount(input logic [7:0] l);
		lcount = 4'h0;
		for (int k = 0; k < 8; k++) lcount = lcount + 4'(l[k]);
	endfunction

	always_comb begin
		next_gr = gr;
		next_fl = flags;
		next_st = st;
		next_cur = cur;
		next_left = left;
		next_done = 1'b0;
		next_ill = 1'b0;
		next_req = mem_req;
		next_we = mem_we;
		next_size = mem_size;
		next_addr = mem_addr;
		next_wdata = mem_wdata;
		next_peek = gr[peek_idx];
		bad = 1'b0;
		sp = gr[SP_IDX];
		opa = rget(gr[cmd.rd[2:0]], cmd.rd, cmd.sz);
		opb = cmd.use_imm ? fext(cmd.imm, cmd.len, 1'b0) : rget(gr[cmd.src[2:0]], cmd.src, cmd.sz);
		ea = REG_RST;
		val = REG_RST;
		ri = 3'h0;
		alu = '0;
		case (st)
			ST_IDLE: if (cmd_valid) begin
				next_cur = cmd;
				next_done = 1'b1;
				next_size = cmd.sz;
				case (cmd.op)
					OP_XFER: begin
						next_gr[cmd.rd[2:0]] = wput(gr[cmd.rd[2:0]], cmd.rd, cmd.sz, opb); // [RULE_01]
						next_fl = setnz(flags, opb, cmd.sz);
						next_fl.v = 1'b0;
					end
					OP_LOAD, OP_STORE: begin
						ri = (cmd.op == OP_LOAD) ? cmd.src[2:0] : cmd.rd[2:0];
						ea = gr[ri] + fext(cmd.imm, cmd.len, 1'b1); // [RULE_18]
						val = rget(gr[cmd.src[2:0]], cmd.src, cmd.sz);
						next_req = 1'b1; // [RULE_01]
						next_we = (cmd.op == OP_STORE);
						next_addr = align(ea, cmd.sz);
						next_wdata = val;
						if (cmd.op == OP_STORE) begin
							next_fl = setnz(flags, val, cmd.sz);
							next_fl.v = 1'b0;
						end
						next_st = ST_MEM;
					end
					OP_POP, OP_PUSH: begin
						bad = (cmd.sz == SZ_B);
						ea = sp - ((cmd.sz == SZ_L) ? LONG_STEP : WORD_STEP);
						val = rget(gr[cmd.rd[2:0]], cmd.rd, cmd.sz);
						next_req = 1'b1;
						next_we = (cmd.op == OP_PUSH);
						next_addr = align((cmd.op == OP_PUSH) ? ea : sp, cmd.sz); // [RULE_03] [RULE_04]
						next_wdata = val;
						if (cmd.op == OP_PUSH) begin
							next_gr[SP_IDX] = ea; // [RULE_04]
							next_fl = setnz(flags, val, cmd.sz);
							next_fl.v = 1'b0;
						end
						next_st = ST_MEM;
					end
					OP_MRD, OP_MWR: begin
						bad = cmd.rlist[SP_IDX] || (lcount(cmd.rlist) < LIST_MIN); // [RULE_07]
						ri = highbit(cmd.rlist);
						next_left = cmd.rlist;
						next_size = SZ_L; // [RULE_05] [RULE_06]
						next_req = 1'b1;
						next_we = (cmd.op == OP_MWR);
						next_addr = align((cmd.op == OP_MWR) ? sp - LONG_STEP : sp, SZ_L);
						next_wdata = gr[ri]; // [RULE_24]
						if (cmd.op == OP_MWR) next_gr[SP_IDX] = sp - LONG_STEP;
						next_st = ST_MEM;
					end
					OP_ADD, OP_SUB, OP_ADC, OP_SBC: begin
						bad = (cmd.op == OP_SUB && cmd.use_imm && cmd.sz == SZ_B) // [RULE_09]
							|| ((cmd.op == OP_ADC || cmd.op == OP_SBC) && cmd.sz != SZ_B); // [RULE_10]
						alu = addsub(opa, opb, (cmd.op == OP_ADC || cmd.op == OP_SBC) && flags.c,
							cmd.op == OP_SUB || cmd.op == OP_SBC, cmd.sz); // [RULE_08] [RULE_10]
						next_gr[cmd.rd[2:0]] = wput(gr[cmd.rd[2:0]], cmd.rd, cmd.sz, alu.r);
						next_fl = setnz(flags, alu.r, cmd.sz);
						next_fl.c = alu.c; // [RULE_20]
						next_fl.v = alu.v; // [RULE_21]
						next_fl.h = alu.h;
						// Carry chains keep zero only while every piece was zero
						if (cmd.op == OP_ADC || cmd.op == OP_SBC) next_fl.z = flags.z && next_fl.z;
					end
					OP_INC, OP_DCR: begin
						bad = !(cmd.step == STEP_1 || (cmd.step == STEP_2 && cmd.sz != SZ_B)); // [RULE_12]
						alu = addsub(opa, 32'(cmd.step), 1'b0, cmd.op == OP_DCR, cmd.sz); // [RULE_11]
						next_gr[cmd.rd[2:0]] = wput(gr[cmd.rd[2:0]], cmd.rd, cmd.sz, alu.r);
						next_fl = setnz(flags, alu.r, cmd.sz);
						next_fl.v = alu.v;
					end
					OP_ADDS, OP_SUBP: begin
						bad = cmd.sz != SZ_L || !(cmd.step == STEP_1 || cmd.step == STEP_2 || cmd.step == STEP_4);
						val = (cmd.op == OP_ADDS) ? gr[cmd.rd[2:0]] + 32'(cmd.step)
							: gr[cmd.rd[2:0]] - 32'(cmd.step);
						next_gr[cmd.rd[2:0]] = val; // [RULE_13]
					end
					OP_DFA, OP_DFS: begin
						bad = (cmd.sz != SZ_B);
						val = 32'((flags.c || (cmd.op == OP_DFA && opa[7:0] > 8'h99)) ? BCD_HI : 8'h00)
							+ 32'((flags.h || (cmd.op == OP_DFA && opa[3:0] > 4'h9)) ? BCD_LO : 8'h00);
						val = (cmd.op == OP_DFA) ? opa + val : opa - val; // [RULE_14]
						next_gr[cmd.rd[2:0]] = wput(gr[cmd.rd[2:0]], cmd.rd, SZ_B, val);
						next_fl = setnz(flags, 32'(val[7:0]), SZ_B);
						if (cmd.op == OP_DFA) next_fl.c = flags.c || opa[7:0] > 8'h99 || val[8];
					end
					OP_MULU, OP_MULS: begin
						bad = (cmd.sz == SZ_L);
						if (cmd.sz == SZ_B) begin
							opa = rget(gr[cmd.rd[2:0]], cmd.rd, SZ_W);
							val = (cmd.op == OP_MULS) ? 32'($signed(opa[7:0]) * $signed(opb[7:0])) // [RULE_16]
								: 32'(opa[7:0] * opb[7:0]); // [RULE_15]
							next_gr[cmd.rd[2:0]] = wput(gr[cmd.rd[2:0]], cmd.rd, SZ_W, val);
							next_fl = setnz(flags, 32'(val[15:0]), SZ_W);
						end else begin
							opa = gr[cmd.rd[2:0]];
							val = (cmd.op == OP_MULS) ? 32'($signed(opa[15:0]) * $signed(opb[15:0])) // [RULE_16]
								: 32'(opa[15:0] * opb[15:0]); // [RULE_15]
							next_gr[cmd.rd[2:0]] = val;
							next_fl = setnz(flags, val, SZ_L);
						end
					end
					OP_DIVU: begin
						// Zero divisor leaves the destination as it was
						bad = (cmd.sz == SZ_L);
						if (cmd.sz == SZ_B && opb[7:0] != 8'h00) begin
							opa = rget(gr[cmd.rd[2:0]], cmd.rd, SZ_W);
							val = {16'h0000, 8'(opa[15:0] % opb[7:0]), 8'(opa[15:0] / opb[7:0])}; // [RULE_17]
							next_gr[cmd.rd[2:0]] = wput(gr[cmd.rd[2:0]], cmd.rd, SZ_W, val);
						end else if (cmd.sz == SZ_W && opb[15:0] != 16'h0000) begin
							opa = gr[cmd.rd[2:0]];
							next_gr[cmd.rd[2:0]] = {16'(opa % opb[15:0]), 16'(opa / opb[15:0])}; // [RULE_17]
						end
					end
					default: bad = 1'b1; // [RULE_02]
				endcase
				if (bad) begin
					next_gr = gr;
					next_fl = flags;
					next_req = 1'b0;
					next_st = ST_IDLE;
					next_done = 1'b0;
					next_ill = 1'b1;
				end else if (next_st == ST_MEM) next_done = 1'b0;
			end
			ST_MEM: if (mem_ack) begin
				next_req = 1'b0;
				next_st = ST_IDLE;
				next_done = 1'b1;
				val = (mem_size == SZ_B) ? 32'(mem_rdata[7:0]) : (mem_size == SZ_W) ? 32'(mem_rdata[15:0]) : mem_rdata;
				case (cur.op)
					OP_LOAD, OP_POP: begin
						if (cur.op == OP_POP)
							next_gr[SP_IDX] = sp + ((cur.sz == SZ_L) ? LONG_STEP : WORD_STEP); // [RULE_03]
						next_gr[cur.rd[2:0]] = wput(next_gr[cur.rd[2:0]], cur.rd, cur.sz, val);
						next_fl = setnz(flags, val, cur.sz);
						next_fl.v = 1'b0;
					end
					OP_MRD: begin
						ri = lowbit(left);
						next_gr[ri] = mem_rdata; // [RULE_24]
						next_gr[SP_IDX] = sp + LONG_STEP; // [RULE_05]
						next_left[ri] = 1'b0;
					end
					OP_MWR: begin
						next_left[highbit(left)] = 1'b0;
						ri = highbit(next_left);
						next_wdata = gr[ri]; // [RULE_24]
						next_addr = sp - LONG_STEP;
						if (next_left != 8'h00) next_gr[SP_IDX] = sp - LONG_STEP; // [RULE_06]
					end
					default: ;
				endcase
				if ((cur.op == OP_MRD || cur.op == OP_MWR) && next_left != 8'h00) begin
					if (cur.op == OP_MRD) next_addr = sp + LONG_STEP;
					next_req = 1'b1;
					next_st = ST_MEM;
					next_done = 1'b0;
				end
			end
			default: next_st = ST_IDLE;
		endcase
		next_rdy = (next_st == ST_IDLE);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			for (int k = 0; k < 8; k++) gr[k] <= REG_RST;
			flags <= FLAGS_RST;
			st <= ST_IDLE;
			cur <= '0;
			left <= 8'h00;
			cmd_ready <= 1'b1;
			done <= 1'b0;
			illegal <= 1'b0;
			mem_req <= 1'b0;
			mem_we <= 1'b0;
			mem_size <= SZ_B;
			mem_addr <= REG_RST;
			mem_wdata <= REG_RST;
			peek_data <= REG_RST;
		end else if (ce) begin
			gr <= next_gr;
			flags <= next_fl;
			st <= next_st;
			cur <= next_cur;
			left <= next_left;
			cmd_ready <= next_rdy;
			done <= next_done;
			illegal <= next_ill;
			mem_req <= next_req;
			mem_we <= next_we;
			mem_size <= next_size;
			mem_addr <= next_addr;
			mem_wdata <= next_wdata;
			peek_data <= next_peek;
		end
	end

	logic acc, cry8;
	logic [31:0] sp_w;
	assign acc = cmd_valid && cmd_ready && ce;
	assign sp_w = gr[SP_IDX];
	assign cry8 = 9'({1'b0, opa[7:0]} + {1'b0, opb[7:0]}) > 9'h0ff;

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	property p_pmove_refused;
		acc && (cmd.op == OP_PRD || cmd.op == OP_PWR) |=> illegal && !mem_req && !done;
	endproperty
	a_pmove_refused: assert property (p_pmove_refused) else $error("Peripheral move accepted"); // [RULE_02]
	property p_pop_addr;
		acc && cmd.op == OP_POP && cmd.sz == SZ_W |=> mem_req && !mem_we && mem_addr == align($past(sp_w), SZ_W);
	endproperty
	a_pop_addr: assert property (p_pop_addr) else $error("Pop address wrong"); // [RULE_03]
	property p_push_predec;
		acc && cmd.op == OP_PUSH && cmd.sz == SZ_L |=> mem_we && sp_w == $past(sp_w) - LONG_STEP;
	endproperty
	a_push_predec: assert property (p_push_predec) else $error("Push did not pre-decrement"); // [RULE_04]
	property p_list_no_sp;
		acc && (cmd.op == OP_MRD || cmd.op == OP_MWR) && cmd.rlist[SP_IDX] |=> illegal ##1 cmd_ready;
	endproperty
	a_list_no_sp: assert property (p_list_no_sp) else $error("Stack pointer in list accepted"); // [RULE_07]
	property p_subimm_byte;
		acc && cmd.op == OP_SUB && cmd.use_imm && cmd.sz == SZ_B |=> illegal && flags == $past(flags);
	endproperty
	a_subimm_byte: assert property (p_subimm_byte) else $error("Byte immediate subtract ran"); // [RULE_09]
	property p_incb_step2;
		acc && (cmd.op == OP_INC || cmd.op == OP_DCR) && cmd.sz == SZ_B && cmd.step == STEP_2 |=> illegal;
	endproperty
	a_incb_step2: assert property (p_incb_step2) else $error("Byte step of two ran"); // [RULE_12]
	property p_add_carry;
		acc && cmd.op == OP_ADD && cmd.sz == SZ_B |=> flags.c == $past(cry8) && done;
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("Byte add carry wrong"); // [RULE_20]
	property p_word_aligned;
		mem_req && mem_size != SZ_B |-> !mem_addr[0];
	endproperty
	a_word_aligned: assert property (p_word_aligned) else $error("Odd word address issued"); // [RULE_22]
endmodule

// file: verilog/ctad_pkg.sv
package ctad_pkg;
	typedef enum logic [4:0] {
		OP_XFER, OP_LOAD, OP_STORE, OP_POP, OP_PUSH, OP_MRD, OP_MWR, OP_PRD, OP_PWR,
		OP_ADD, OP_SUB, OP_ADC, OP_SBC, OP_INC, OP_DCR, OP_ADDS, OP_SUBP,
		OP_DFA, OP_DFS, OP_MULU, OP_MULS, OP_DIVU
	} ctad_op_e;
	typedef enum logic [1:0] {SZ_B, SZ_W, SZ_L} ctad_size_e;
	typedef enum logic [1:0] {LEN_8, LEN_16, LEN_24, LEN_32} ctad_len_e;
	typedef enum logic {ST_IDLE, ST_MEM} ctad_state_e;
	typedef struct packed {
		ctad_op_e   op;
		ctad_size_e sz;
		logic [3:0] rd;
		logic [3:0] src;
		logic       use_imm;
		logic [31:0] imm;
		ctad_len_e  len;
		logic [2:0] step;
		logic [7:0] rlist;
	} ctad_cmd_s;
	typedef struct packed {
		logic h;
		logic n;
		logic z;
		logic v;
		logic c;
	} ctad_flags_s;
	typedef struct packed {
		logic [31:0] r;
		logic        c;
		logic        v;
		logic        h;
	} ctad_alu_s;
	localparam logic [2:0]  SP_IDX    = 3'h7;
	localparam logic [31:0] REG_RST   = 32'h0000_0000;
	localparam logic [4:0]  FLAGS_RST = 5'h00;
	localparam logic [3:0]  LIST_MIN  = 4'h2;
	localparam logic [2:0]  STEP_1    = 3'h1;
	localparam logic [2:0]  STEP_2    = 3'h2;
	localparam logic [2:0]  STEP_4    = 3'h4;
	localparam logic [31:0] WORD_STEP = 32'h0000_0002;
	localparam logic [31:0] LONG_STEP = 32'h0000_0004;
	localparam logic [7:0]  BCD_HI    = 8'h60;
	localparam logic [7:0]  BCD_LO    = 8'h06;
endpackage

// file: testbench/ctad_mem_model.sv
`timescale 1ns/10ps
module ctad_mem_model
	import ctad_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  ctad_size_e       mem_size,
	input  wire logic [31:0] mem_addr,
	input  wire logic [31:0] mem_wdata,
	input  wire logic [3:0]  lat,
	output logic [31:0]      mem_rdata,
	output logic             mem_ack,
	output logic             odd_seen
);
	logic [7:0]  mem [256];
	logic [3:0]  cnt;
	logic [31:0] v;
	logic [7:0]  a;
	int          nb;
	initial begin
		foreach (mem[i]) mem[i] = 8'h00;
		cnt = 4'h0;
		mem_ack = 1'b0;
		odd_seen = 1'b0;
		mem_rdata = 32'h0000_0000;
	end
	// Ack after lat idle cycles; a chained request may follow the cycle after an ack
	always @(posedge clk) begin
		mem_ack <= 1'b0;
		// Scrambled outside the ack cycle so stale data never looks valid
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack) begin
			if (cnt < lat) begin
				cnt <= cnt + 4'h1;
			end else begin
				cnt <= 4'h0;
				mem_ack <= 1'b1;
				a = mem_addr[7:0];
				nb = (mem_size == SZ_B) ? 1 : (mem_size == SZ_W) ? 2 : 4;
				if (nb > 1 && a[0]) odd_seen <= 1'b1;
				v = 32'h0000_0000;
				for (int i = 0; i < nb; i++) begin
					if (mem_we) mem[a + 8'(i)] = mem_wdata[8 * (nb - 1 - i) +: 8];
					v = {v[23:0], mem[a + 8'(i)]};
				end
				mem_rdata <= v;
			end
		end
	end
endmodule

// file: testbench/cpu_transfer_arith_datapath_tb_top.sv
`timescale 1ns/10ps
module cpu_transfer_arith_datapath_tb_top
	import ctad_pkg::*;
;
	localparam logic [31:0] Z32 = 32'h0000_0000;
	logic        clk;
	logic        srst;
	logic        ce;
	logic        cmd_valid;
	ctad_cmd_s   cmd;
	logic        cmd_ready;
	logic        done;
	logic        illegal;
	ctad_flags_s flags;
	logic        mem_req;
	logic        mem_we;
	ctad_size_e  mem_size;
	logic [31:0] mem_addr;
	logic [31:0] mem_wdata;
	logic [31:0] mem_rdata;
	logic        mem_ack;
	logic        odd_seen;
	logic [2:0]  peek_idx;
	logic [31:0] peek_data;
	logic [3:0]  lat;
	int          error_cnt;
	int          compares;
	int          cyc;

	ctad_datapath DUT (.clk(clk), .srst(srst), .ce(ce), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_ready(cmd_ready), .done(done), .illegal(illegal), .flags(flags), .mem_req(mem_req),
		.mem_we(mem_we), .mem_size(mem_size), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack), .peek_idx(peek_idx), .peek_data(peek_data));
	ctad_mem_model u_mem (.clk(clk), .mem_req(mem_req), .mem_we(mem_we), .mem_size(mem_size),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .lat(lat), .mem_rdata(mem_rdata),
		.mem_ack(mem_ack), .odd_seen(odd_seen));

	always #20 clk = ~clk;

	task automatic end_sim();
		$display("Checks %0d, errors %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// Well above the 80 commands of the run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			end_sim();
		end
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chf(input logic [4:0] e, input logic [4:0] m = 5'h0F);
		chk("flags", {27'h0, e & m}, {27'h0, flags & m});
	endtask

	function automatic ctad_cmd_s mk(ctad_op_e op, ctad_size_e sz, logic [3:0] rd, logic [3:0] sr,
		logic ui, logic [31:0] imm, logic [2:0] st = STEP_1, logic [7:0] rl = 8'h00,
		ctad_len_e ln = LEN_32);
		return '{op, sz, rd, sr, ui, imm, ln, st, rl};
	endfunction

	function automatic logic [31:0] memw(input logic [7:0] a);
		return {u_mem.mem[a], u_mem.mem[a + 8'h01], u_mem.mem[a + 8'h02], u_mem.mem[a + 8'h03]};
	endfunction

	// Done or refusal is a one-cycle pulse, so it is looked at after every edge
	task automatic run(input ctad_cmd_s c, input logic bad = 1'b0);
		logic d;
		logic il;
		d = 1'b0;
		il = 1'b0;
		@(posedge clk);
		cmd <= c;
		cmd_valid <= 1'b1;
		@(posedge clk);
		cmd_valid <= 1'b0;
		for (int n = 0; n < 200 && !d && !il; n++) begin
			#1;
			d = (done === 1'b1);
			il = (illegal === 1'b1);
			if (!d && !il) @(posedge clk);
		end
		chk("outcome", {30'h0, bad, !bad}, {30'h0, il, d});
	endtask

	task automatic chk_reg(input logic [2:0] r, input logic [31:0] e);
		@(posedge clk);
		peek_idx <= r;
		@(posedge clk);
		#1;
		chk("register", e, peek_data);
	endtask

	task automatic setl(input logic [2:0] r, input logic [31:0] v);
		run(mk(OP_XFER, SZ_L, {1'b0, r}, 4'h0, 1'b1, v));
	endtask

	task automatic t_reset();
		chk_reg(3'h3, Z32);
		chf(5'h00, 5'h1F);
		chk("ready", 32'h0000_0001, {31'h0, cmd_ready});
	endtask

	task automatic t_move();
		logic [31:0] ex [4];
		ex = '{32'h0000_00A5, 32'h0000_C3A5, 32'h00E1_C3A5, 32'hF0E1_C3A5};
		for (int i = 0; i < 4; i++) begin
			run(mk(OP_XFER, SZ_L, 4'h1, 4'h0, 1'b1, 32'hF0E1_C3A5, STEP_1, 8'h00, ctad_len_e'(i)));
			chk_reg(3'h1, ex[i]);
		end
		chf(5'h08, 5'h0E);
		run(mk(OP_XFER, SZ_W, 4'hA, 4'h1, 1'b0, Z32));
		chk_reg(3'h2, 32'hC3A5_0000);
		setl(3'h3, 32'h0000_0040);
		run(mk(OP_STORE, SZ_L, 4'h3, 4'h1, 1'b0, 32'h0000_00FC, STEP_1, 8'h00, LEN_8));
		chk("stored", 32'hF0E1_C3A5, memw(8'h3C));
		run(mk(OP_LOAD, SZ_W, 4'h4, 4'h3, 1'b0, 32'h0000_00FE, STEP_1, 8'h00, LEN_8));
		chk_reg(3'h4, 32'h0000_C3A5);
	endtask

	task automatic t_illegal();
		ctad_cmd_s c [13];
		c[0] = mk(OP_PRD, SZ_B, 4'h5, 4'h0, 1'b0, Z32);
		c[1] = mk(OP_PWR, SZ_B, 4'h5, 4'h0, 1'b0, Z32);
		c[2] = mk(OP_SUB, SZ_B, 4'hD, 4'h0, 1'b1, 32'h0000_0001);
		c[3] = mk(OP_INC, SZ_B, 4'hD, 4'h0, 1'b0, Z32, STEP_2);
		c[4] = mk(OP_ADDS, SZ_L, 4'h5, 4'h0, 1'b0, Z32, 3'h3);
		c[5] = mk(OP_ADC, SZ_W, 4'h5, 4'h0, 1'b1, Z32);
		c[6] = mk(OP_DFA, SZ_W, 4'h5, 4'h0, 1'b0, Z32);
		c[7] = mk(OP_MRD, SZ_L, 4'h0, 4'h0, 1'b0, Z32, STEP_1, 8'h81);
		c[8] = mk(OP_MWR, SZ_L, 4'h0, 4'h0, 1'b0, Z32, STEP_1, 8'h04);
		c[9] = mk(OP_PUSH, SZ_B, 4'hD, 4'h0, 1'b0, Z32);
		c[10] = mk(OP_MULU, SZ_L, 4'h5, 4'h1, 1'b0, Z32);
		c[11] = mk(OP_DIVU, SZ_L, 4'h5, 4'h1, 1'b0, Z32);
		c[12] = mk(OP_DCR, SZ_W, 4'h5, 4'h0, 1'b0, Z32, STEP_4);
		setl(3'h5, 32'h1234_5678);
		foreach (c[i]) run(c[i], 1'b1);
		chk_reg(3'h5, 32'h1234_5678);
	endtask

	task automatic t_addsub();
		setl(3'h1, 32'h7FFF_FFFF);
		setl(3'h2, 32'h0000_0001);
		run(mk(OP_ADD, SZ_L, 4'h1, 4'h2, 1'b0, Z32));
		chk_reg(3'h1, 32'h8000_0000);
		chf(5'h0A);
		setl(3'h0, 32'h0000_00FF);
		run(mk(OP_ADD, SZ_B, 4'h8, 4'h0, 1'b1, 32'h0000_0001));
		chf(5'h05);
		run(mk(OP_ADC, SZ_B, 4'h8, 4'h0, 1'b1, Z32));
		chk_reg(3'h0, 32'h0000_0001);
		chf(5'h00);
		run(mk(OP_SBC, SZ_B, 4'h8, 4'h0, 1'b1, 32'h0000_0001));
		chk_reg(3'h0, Z32);
		chf(5'h00);
		run(mk(OP_SUB, SZ_W, 4'h0, 4'h2, 1'b0, Z32));
		chk_reg(3'h0, 32'h0000_FFFF);
		chf(5'h09);
		run(mk(OP_SUB, SZ_W, 4'h0, 4'h0, 1'b1, 32'h0000_FFFF));
		chf(5'h04);
	endtask

	task automatic t_incdec();
		setl(3'h2, 32'h1234_7FFE);
		run(mk(OP_INC, SZ_W, 4'h2, 4'h0, 1'b0, Z32, STEP_2));
		chk_reg(3'h2, 32'h1234_8000);
		chf(5'h0A, 5'h0E);
		setl(3'h2, Z32);
		run(mk(OP_DCR, SZ_L, 4'h2, 4'h0, 1'b0, Z32, STEP_1));
		chk_reg(3'h2, 32'hFFFF_FFFF);
		setl(3'h0, 32'h0000_00FF);
		run(mk(OP_INC, SZ_B, 4'h8, 4'h0, 1'b0, Z32, STEP_1));
		chk_reg(3'h0, Z32);
		chf(5'h04, 5'h0E);
		run(mk(OP_ADDS, SZ_L, 4'h2, 4'h0, 1'b0, Z32, STEP_4));
		chk_reg(3'h2, 32'h0000_0003);
		chf(5'h04, 5'h0E);
		run(mk(OP_SUBP, SZ_L, 4'h2, 4'h0, 1'b0, Z32, STEP_2));
		chk_reg(3'h2, 32'h0000_0001);
	endtask

	task automatic t_bcd();
		setl(3'h0, 32'h0000_0019);
		run(mk(OP_ADD, SZ_B, 4'h8, 4'h0, 1'b1, 32'h0000_0028));
		run(mk(OP_DFA, SZ_B, 4'h8, 4'h0, 1'b0, Z32));
		chk_reg(3'h0, 32'h0000_0047);
		setl(3'h1, 32'h0000_0019);
		run(mk(OP_SUB, SZ_B, 4'h8, 4'h9, 1'b0, Z32));
		run(mk(OP_DFS, SZ_B, 4'h8, 4'h0, 1'b0, Z32));
		chk_reg(3'h0, 32'h0000_0028);
	endtask

	task automatic t_muldiv();
		setl(3'h3, 32'h0000_FFFF);
		setl(3'h4, 32'h0000_FFFF);
		run(mk(OP_MULU, SZ_W, 4'h3, 4'h4, 1'b0, Z32));
		chk_reg(3'h3, 32'hFFFE_0001);
		setl(3'h3, 32'h0000_FFFF);
		run(mk(OP_MULS, SZ_W, 4'h3, 4'h4, 1'b0, Z32));
		chk_reg(3'h3, 32'h0000_0001);
		setl(3'h5, 32'h0000_0010);
		run(mk(OP_MULU, SZ_B, 4'h5, 4'hD, 1'b0, Z32));
		chk_reg(3'h5, 32'h0000_0100);
		setl(3'h5, 32'h0000_00FE);
		run(mk(OP_MULS, SZ_B, 4'h5, 4'hD, 1'b0, Z32));
		chk_reg(3'h5, 32'h0000_0004);
		setl(3'h6, 32'h0001_0005);
		setl(3'h1, 32'h0000_0010);
		setl(3'h2, 32'h8000_0000);
		run(mk(OP_DIVU, SZ_W, 4'h6, 4'h1, 1'b0, Z32));
		chk_reg(3'h6, 32'h0005_1000);
		chf(5'h08, 5'h0E);
		setl(3'h5, 32'h0000_0107);
		run(mk(OP_DIVU, SZ_B, 4'h5, 4'h9, 1'b0, Z32));
		chk_reg(3'h5, 32'h0000_0710);
		setl(3'h2, Z32);
		run(mk(OP_DIVU, SZ_W, 4'h6, 4'h2, 1'b0, Z32));
		chk_reg(3'h6, 32'h0005_1000);
	endtask

	task automatic t_stack();
		setl(3'h7, 32'h0000_0081);
		setl(3'h1, 32'hCAFE_F00D);
		run(mk(OP_PUSH, SZ_L, 4'h1, 4'h0, 1'b0, Z32));
		chk_reg(3'h7, 32'h0000_007D);
		chk("pushed", 32'hCAFE_F00D, memw(8'h7C));
		run(mk(OP_POP, SZ_L, 4'h2, 4'h0, 1'b0, Z32));
		chk_reg(3'h2, 32'hCAFE_F00D);
		chk_reg(3'h7, 32'h0000_0081);
		@(posedge clk);
		lat <= 4'h3;
		setl(3'h3, Z32);
		run(mk(OP_PUSH, SZ_W, 4'h9, 4'h0, 1'b0, Z32));
		run(mk(OP_POP, SZ_W, 4'h3, 4'h0, 1'b0, Z32));
		chk_reg(3'h3, 32'h0000_CAFE);
		chk_reg(3'h7, 32'h0000_0081);
		chk("odd access", Z32, {31'h0, odd_seen});
	endtask

	task automatic t_multi();
		for (int i = 0; i < 4; i++) setl(3'(i), 32'(i + 1) * 32'h0101_0101);
		setl(3'h7, 32'h0000_00C0);
		run(mk(OP_MWR, SZ_L, 4'h0, 4'h0, 1'b0, Z32, STEP_1, 8'h0F));
		chk_reg(3'h7, 32'h0000_00B0);
		chk("top slot", 32'h0404_0404, memw(8'hBC));
		chk("bottom slot", 32'h0101_0101, memw(8'hB0));
		for (int i = 0; i < 4; i++) setl(3'(i), Z32);
		run(mk(OP_MRD, SZ_L, 4'h0, 4'h0, 1'b0, Z32, STEP_1, 8'h0F));
		for (int i = 0; i < 4; i++) chk_reg(3'(i), 32'(i + 1) * 32'h0101_0101);
		chk_reg(3'h7, 32'h0000_00C0);
	endtask

	initial begin
		clk = 1'b0;
		srst = 1'b1;
		ce = 1'b1;
		cmd_valid = 1'b0;
		cmd = '0;
		peek_idx = 3'h0;
		lat = 4'h0;
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_move();
		t_illegal();
		t_addsub();
		t_incdec();
		t_bcd();
		t_muldiv();
		t_stack();
		t_multi();
		end_sim();
	end
endmodule
